// file: rtl/smc_regs.svh
`ifndef SMC_REGS_SVH
`define SMC_REGS_SVH

// =====================================================
// Mode select codes written by software
`define SMC_MODE_NONE 2'h0
`define SMC_MODE_PAUSE 2'h1
`define SMC_MODE_STOP 2'h2
`define SMC_MODE_XSTOP 2'h3

// =====================================================
// Wake source bit positions
`define SMC_SRC_N 9
`define SMC_SRC_PIN_A 0
`define SMC_SRC_PIN_B 1
`define SMC_SRC_PIN_C 2
`define SMC_SRC_PIN_E 3
`define SMC_SRC_PIN_F 4
`define SMC_SRC_PORT0 5
`define SMC_SRC_USB 6
`define SMC_SRC_BASE_TMR 7
`define SMC_SRC_IR_RX 8
// Full stop wakes on bits 0..6, crystal stop on all nine
`define SMC_STOP_WAKE_MASK 9'h07F
`define SMC_XSTOP_WAKE_MASK 9'h1FF

// =====================================================
// Timing
`define SMC_CLK_PERIOD_NS 10
`define SMC_SETTLE_NS 2000
`define SMC_SETTLE_CYC ((`SMC_SETTLE_NS + `SMC_CLK_PERIOD_NS - 1) / `SMC_CLK_PERIOD_NS)
`define SMC_CNT_W 16

`endif

// file: rtl/smc_pkg.sv
// =====================================================
// Types shared by the standby controller modules
package smc_pkg;

  // Controller states
  typedef enum logic [2:0] {
    SMC_RUN_ST = 3'b000, // Normal execution
    SMC_PAUSE_ST = 3'b001, // CPU paused, peripherals alive
    SMC_STOP_ST = 3'b010, // Everything stopped except the slow RC, which the watchdog controls
    SMC_XSTOP_ST = 3'b011, // Stopped except timekeeping
    SMC_SETTLE_ST = 3'b100 // Oscillators restarting
  } smc_state_type;

  // Complete state of the main controller
  typedef struct packed {
    smc_state_type state; // Current mode
    logic [15:0] cnt; // Settle countdown
    logic clr_s1; // Clear pin sync stage 1
    logic clr_s2; // Clear pin sync stage 2
    logic xtal_keep; // Crystal state caught at entry
    logic cpu_run; // Output images
    logic periph_en;
    logic timek_en;
    logic pll_ref_en;
    logic usb_pll_en;
    logic cer_en;
    logic rc_en;
    logic xtal_en;
    logic lsrc_en;
    logic sys_reset;
    logic irq_resume;
  } smc_ctrl_st_type;

endpackage : smc_pkg

// file: rtl/smc_if.sv
`timescale 1ns/1ns
// =====================================================
// Link between the controller and its wake qualifier
interface smc_if
  import smc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b
);
  smc_state_type mode; // Controller state
  logic [8:0] src; // Raw wake requests
  logic lvl_a; // Pin a set for level detection
  logic lvl_b; // Pin b set for level detection
  logic irq_any; // Any interrupt established
  logic wake; // Qualified wake for current mode

  modport ctrl (
    input clk,
    input rst_b,
    output mode,
    output src,
    output lvl_a,
    output lvl_b,
    output irq_any,
    input wake
  );

  modport qual (
    input clk,
    input rst_b,
    input mode,
    input src,
    input lvl_a,
    input lvl_b,
    input irq_any,
    output wake
  );
endinterface : smc_if

// file: rtl/smc_wake.sv
`timescale 1ns/1ns
`include "smc_regs.svh"
// =====================================================
// Wake qualifier: purely combinational, so a wake seen
// here reaches the controller state in the same cycle
module smc_wake
  import smc_pkg::*;
(
  smc_if.qual bus
);
  localparam logic [8:0] STOP_MASK = `SMC_STOP_WAKE_MASK;
  localparam logic [8:0] XSTOP_MASK = `SMC_XSTOP_WAKE_MASK;

  logic [8:0] src_q; // Sources after level qualification
  logic [8:0] hit_stop; // Sources that end full stop
  logic [8:0] hit_xstop; // Sources that end crystal stop

  // Edge-set requests on pins a and b are discarded
  always_comb begin
    src_q = bus.src;
    src_q[`SMC_SRC_PIN_A] = bus.src[`SMC_SRC_PIN_A] & bus.lvl_a;
    src_q[`SMC_SRC_PIN_B] = bus.src[`SMC_SRC_PIN_B] & bus.lvl_b;
  end

  // =====================================================
  // Per-source mode masks
  for (genvar i = 0; i < `SMC_SRC_N; i++) begin : g_src
    assign hit_stop[i] = src_q[i] & STOP_MASK[i];
    assign hit_xstop[i] = src_q[i] & XSTOP_MASK[i];
  end

  // Wake decision per mode
  always_comb begin
    case (bus.mode)
      SMC_PAUSE_ST: bus.wake = bus.irq_any;
      SMC_STOP_ST: bus.wake = |hit_stop;
      SMC_XSTOP_ST: bus.wake = |hit_xstop;
      default: bus.wake = 1'b0;
    endcase
  end

  // =====================================================
  // Checks
  default clocking cb @(posedge bus.clk); endclocking
  default disable iff (!bus.rst_b);

  edge_pins_ignored_a: assert property (
    (bus.mode == SMC_STOP_ST && !bus.lvl_a && !bus.lvl_b && bus.src[8:2] == 7'h00)
    |-> !bus.wake)
    else $error("edge request on pin a or b woke full stop");

  xstop_timer_wake_a: assert property (
    (bus.mode == SMC_XSTOP_ST && (bus.src[`SMC_SRC_BASE_TMR] || bus.src[`SMC_SRC_IR_RX]))
    |-> bus.wake)
    else $error("timer or IR request missed in crystal stop");

  stop_timer_blind_a: assert property (
    (bus.mode == SMC_STOP_ST && bus.src[6:0] == 7'h00) |-> !bus.wake)
    else $error("full stop woke on a source it must ignore");
endmodule : smc_wake

// file: rtl/smc_ctrl.sv
`timescale 1ns/1ns
`include "smc_regs.svh"
// =====================================================
// Standby controller: pause, full stop, crystal stop
module smc_ctrl
  import smc_pkg::*;
#(
  parameter int SETTLE_CYCLES = `SMC_SETTLE_CYC // Restart wait after a stop
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic EXTERNAL_CLEAR_PIN_B,
  input wire logic WDT_RESET,
  input wire logic WDT_LSRC_ON,
  input wire logic MODE_WR,
  input wire logic [1:0] MODE_SEL,
  input wire logic CFG_PLL_ON,
  input wire logic CFG_CERAMIC_ON,
  input wire logic CFG_RC_ON,
  input wire logic CFG_XTAL_ON,
  input wire logic IRQ_ANY,
  input wire logic EXT_IRQ_PIN_A_REQ,
  input wire logic EXT_IRQ_PIN_B_REQ,
  input wire logic EXT_IRQ_PIN_C_REQ,
  input wire logic EXT_IRQ_PIN_E_REQ,
  input wire logic EXT_IRQ_PIN_F_REQ,
  input wire logic EXT_IRQ_PIN_A_LEVEL,
  input wire logic EXT_IRQ_PIN_B_LEVEL,
  input wire logic PORT0_IRQ,
  input wire logic USB_BUS_ACTIVE_IRQ,
  input wire logic BASE_TIMER_IRQ,
  input wire logic IR_RX_IRQ,
  output logic CPU_RUN_EN,
  output logic PERIPH_CLK_EN,
  output logic TIMEKEEP_CLK_EN,
  output logic PLL_REF_EN,
  output logic USB_PLL_EN,
  output logic CERAMIC_RESONATOR_OSC_EN,
  output logic RC_OSC_EN,
  output logic XTAL_OSC_EN,
  output logic LSRC_OSC_EN,
  output logic SYS_RESET,
  output logic IRQ_RESUME,
  output logic [2:0] STANDBY_STATE
);

  // =====================================================
  // Elaboration checks
  if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535) begin : g_bad_settle
    // The settle counter is 16 bits wide, so longer waits cannot be held
    $error("SETTLE_CYCLES must lie in 1..65535");
  end

  smc_ctrl_st_type st_ff; // Registered state
  smc_ctrl_st_type nxt_st; // Next state
  logic rst_evt; // Reset-type wake this cycle

  // =====================================================
  // Wake qualifier
  smc_if bus (
    .clk(CLK),
    .rst_b(RST_B)
  );

  smc_wake u_wake (
    .bus(bus.qual)
  );

  // Feed raw requests to the qualifier; it is combinational, so a
  // wake is acted on at the very edge that sees it
  assign bus.mode = st_ff.state;
  assign bus.src = {IR_RX_IRQ, BASE_TIMER_IRQ, USB_BUS_ACTIVE_IRQ, PORT0_IRQ,
                    EXT_IRQ_PIN_F_REQ, EXT_IRQ_PIN_E_REQ, EXT_IRQ_PIN_C_REQ,
                    EXT_IRQ_PIN_B_REQ, EXT_IRQ_PIN_A_REQ};
  assign bus.lvl_a = EXT_IRQ_PIN_A_LEVEL;
  assign bus.lvl_b = EXT_IRQ_PIN_B_LEVEL;
  assign bus.irq_any = IRQ_ANY;

  // Clear pin (after two flops) or watchdog reset ends any state
  // A reset cause outranks every wake and every mode write
  assign rst_evt = !st_ff.clr_s2 || WDT_RESET;

  // =====================================================
  // Next-state logic
  always_comb begin
    nxt_st = st_ff;
    // Pin synchroniser: stage 1 is read only by stage 2
    nxt_st.clr_s1 = EXTERNAL_CLEAR_PIN_B;
    nxt_st.clr_s2 = st_ff.clr_s1;
    nxt_st.irq_resume = 1'b0;
    nxt_st.sys_reset = rst_evt;
    if (rst_evt) begin
      // Reset wake: restart from the reset state in any mode
      nxt_st.state = SMC_RUN_ST;
      nxt_st.cnt = 16'h0000;
    end else begin
      case (st_ff.state)
        SMC_RUN_ST: begin
          // Mode write takes effect on the next edge
          if (MODE_WR) begin
            if (MODE_SEL == `SMC_MODE_PAUSE) begin
              nxt_st.state = SMC_PAUSE_ST;
            end else if (MODE_SEL == `SMC_MODE_STOP) begin
              nxt_st.state = SMC_STOP_ST;
            end else if (MODE_SEL == `SMC_MODE_XSTOP) begin
              nxt_st.state = SMC_XSTOP_ST;
              nxt_st.xtal_keep = st_ff.xtal_en;
            end
          end
        end
        SMC_PAUSE_ST: begin
          // Clocks never stopped, so resume at once
          if (bus.wake) begin
            nxt_st.state = SMC_RUN_ST;
            nxt_st.irq_resume = 1'b1;
          end
        end
        SMC_STOP_ST, SMC_XSTOP_ST: begin
          // Oscillators need time before the CPU may run
          if (bus.wake) begin
            nxt_st.state = SMC_SETTLE_ST;
            nxt_st.cnt = SETTLE_CYCLES[15:0];
          end
        end
        SMC_SETTLE_ST: begin
          // Count the restart wait down; CPU and peripherals stay held
          if (st_ff.cnt <= 16'h0001) begin
            nxt_st.state = SMC_RUN_ST;
            nxt_st.cnt = 16'h0000;
            nxt_st.irq_resume = 1'b1;
          end else begin
            nxt_st.cnt = st_ff.cnt - 16'h0001;
          end
        end
        default: begin
          // Unused code: recover to run
          nxt_st.state = SMC_RUN_ST;
        end
      endcase
    end

    // =====================================================
    // Output images, derived from the next state so every
    // output changes on the same edge as the state
    nxt_st.cpu_run = (nxt_st.state == SMC_RUN_ST) && !rst_evt;
    nxt_st.periph_en = (nxt_st.state == SMC_RUN_ST) ||
                       (nxt_st.state == SMC_PAUSE_ST);
    nxt_st.timek_en = (nxt_st.state != SMC_STOP_ST) &&
                      (nxt_st.state != SMC_SETTLE_ST);
    // Slow RC is owned by the watchdog in every state
    nxt_st.lsrc_en = WDT_LSRC_ON;
    case (nxt_st.state)
      SMC_STOP_ST: begin
        // Every fast oscillator off, crystal too
        nxt_st.pll_ref_en = 1'b0;
        nxt_st.cer_en = 1'b0;
        nxt_st.rc_en = 1'b0;
        nxt_st.xtal_en = 1'b0;
      end
      SMC_XSTOP_ST: begin
        // Crystal held as caught at entry
        nxt_st.pll_ref_en = 1'b0;
        nxt_st.cer_en = 1'b0;
        nxt_st.rc_en = 1'b0;
        nxt_st.xtal_en = nxt_st.xtal_keep;
      end
      default: begin
        // Run, pause, settle: software settings apply
        nxt_st.pll_ref_en = CFG_PLL_ON;
        nxt_st.cer_en = CFG_CERAMIC_ON;
        nxt_st.rc_en = CFG_RC_ON;
        nxt_st.xtal_en = CFG_XTAL_ON;
      end
    endcase
    // USB PLL cannot outlive its reference clock
    nxt_st.usb_pll_en = nxt_st.pll_ref_en;
  end

  // =====================================================
  // State register; reset image is all zero, which also
  // reads as clear pin low for two cycles, stretching reset
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // =====================================================
  // Outputs straight from the register
  assign CPU_RUN_EN = st_ff.cpu_run;
  assign PERIPH_CLK_EN = st_ff.periph_en;
  assign TIMEKEEP_CLK_EN = st_ff.timek_en;
  assign PLL_REF_EN = st_ff.pll_ref_en;
  assign USB_PLL_EN = st_ff.usb_pll_en;
  assign CERAMIC_RESONATOR_OSC_EN = st_ff.cer_en;
  assign RC_OSC_EN = st_ff.rc_en;
  assign XTAL_OSC_EN = st_ff.xtal_en;
  assign LSRC_OSC_EN = st_ff.lsrc_en;
  assign SYS_RESET = st_ff.sys_reset;
  assign IRQ_RESUME = st_ff.irq_resume;
  assign STANDBY_STATE = st_ff.state;

  // =====================================================
  // Checks
  // Every check runs on the one system clock and is quiet while
  // the asynchronous reset is applied; the clear pin and the
  // watchdog are checked as ordinary wake causes instead, since
  // they may arrive in any state
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  pause_gating_a: assert property (
    st_ff.state == SMC_PAUSE_ST |-> !CPU_RUN_EN && PERIPH_CLK_EN && TIMEKEEP_CLK_EN)
    else $error("pause gating wrong");

  pause_osc_keep_a: assert property (
    st_ff.state == SMC_PAUSE_ST |->
      CERAMIC_RESONATOR_OSC_EN == $past(CFG_CERAMIC_ON) &&
      XTAL_OSC_EN == $past(CFG_XTAL_ON) && RC_OSC_EN == $past(CFG_RC_ON))
    else $error("pause changed an oscillator");

  pause_wake_a: assert property (
    (st_ff.state == SMC_PAUSE_ST && IRQ_ANY && !rst_evt) |=> CPU_RUN_EN && IRQ_RESUME)
    else $error("pause did not end on interrupt");

  stop_gating_a: assert property (
    st_ff.state == SMC_STOP_ST |-> !CPU_RUN_EN && !PERIPH_CLK_EN && !TIMEKEEP_CLK_EN &&
      !PLL_REF_EN && !CERAMIC_RESONATOR_OSC_EN && !RC_OSC_EN && !XTAL_OSC_EN)
    else $error("full stop left something running");

  lsrc_follow_a: assert property (
    1'b1 |=> LSRC_OSC_EN == $past(WDT_LSRC_ON))
    else $error("slow RC not following watchdog control");

  stop_wake_a: assert property (
    (st_ff.state == SMC_STOP_ST && PORT0_IRQ && !rst_evt) |=> st_ff.state == SMC_SETTLE_ST)
    else $error("port 0 request did not end full stop");

  xstop_gating_a: assert property (
    st_ff.state == SMC_XSTOP_ST |-> TIMEKEEP_CLK_EN && !PERIPH_CLK_EN && !CPU_RUN_EN &&
      !PLL_REF_EN && !CERAMIC_RESONATOR_OSC_EN && !RC_OSC_EN)
    else $error("crystal stop gating wrong");

  xtal_hold_a: assert property (
    (st_ff.state == SMC_RUN_ST && MODE_WR && MODE_SEL == `SMC_MODE_XSTOP && !rst_evt)
    ##1 (st_ff.state == SMC_XSTOP_ST) [*2] |-> XTAL_OSC_EN == $past(XTAL_OSC_EN, 2))
    else $error("crystal state changed in crystal stop");

  usb_pll_ref_a: assert property (
    USB_PLL_EN |-> PLL_REF_EN)
    else $error("USB PLL on without reference");

  mode_write_a: assert property (
    (st_ff.state == SMC_RUN_ST && MODE_WR && MODE_SEL == `SMC_MODE_STOP && !rst_evt)
    |=> st_ff.state == SMC_STOP_ST && !CPU_RUN_EN)
    else $error("stop write not applied next cycle");

  settle_resume_a: assert property (
    (st_ff.state == SMC_SETTLE_ST && st_ff.cnt == 16'h0001 && !rst_evt)
    |=> CPU_RUN_EN && IRQ_RESUME ##1 !IRQ_RESUME)
    else $error("interrupt wake did not resume");

  reset_wake_a: assert property (
    WDT_RESET |=> SYS_RESET && st_ff.state == SMC_RUN_ST && !IRQ_RESUME)
    else $error("watchdog reset did not restart");

  settle_gating_a: assert property (
    st_ff.state == SMC_SETTLE_ST |-> !CPU_RUN_EN && !PERIPH_CLK_EN && !TIMEKEEP_CLK_EN)
    else $error("settle let the CPU or peripherals run");

  settle_osc_a: assert property (
    st_ff.state == SMC_SETTLE_ST |-> PLL_REF_EN == $past(CFG_PLL_ON) &&
      RC_OSC_EN == $past(CFG_RC_ON) && XTAL_OSC_EN == $past(CFG_XTAL_ON))
    else $error("oscillators not restarted in settle");

  xstop_ir_wake_a: assert property (
    (st_ff.state == SMC_XSTOP_ST && IR_RX_IRQ && !rst_evt) |=> st_ff.state == SMC_SETTLE_ST)
    else $error("IR request did not end crystal stop");

  clear_pin_wake_a: assert property (
    !st_ff.clr_s2 |=> SYS_RESET && !CPU_RUN_EN && st_ff.state == SMC_RUN_ST)
    else $error("clear pin did not restart");

  pause_hold_a: assert property (
    (st_ff.state == SMC_PAUSE_ST && !IRQ_ANY && !rst_evt) |=> st_ff.state == SMC_PAUSE_ST)
    else $error("pause ended with no interrupt");

  // =====================================================
  // Cover points for the main round trips through standby
  pause_round_c: cover property (
    st_ff.state == SMC_PAUSE_ST ##1 st_ff.state == SMC_RUN_ST);
  stop_settle_c: cover property (
    st_ff.state == SMC_STOP_ST ##1 st_ff.state == SMC_SETTLE_ST);
  xstop_timer_c: cover property (
    st_ff.state == SMC_XSTOP_ST && BASE_TIMER_IRQ ##1 st_ff.state == SMC_SETTLE_ST);
  reset_wake_c: cover property (
    st_ff.state == SMC_XSTOP_ST && rst_evt ##1 SYS_RESET);
  settle_done_c: cover property (
    st_ff.state == SMC_SETTLE_ST ##1 IRQ_RESUME);
endmodule : smc_ctrl

// file: bench/smc_partner.sv
`timescale 1ns/1ns
// =====================================
// Far side: wake sources as level requests
module smc_partner (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [8:0] SET, // One-cycle raise from the bench
  input wire logic IRQ_RESUME, // CPU has taken the interrupt
  input wire logic SYS_RESET, // Chip reset clears every request
  output logic [8:0] SRC, // Held request levels
  output logic IRQ_ANY // Any request established
);
  // A request stands until served, so a slow wake still sees it
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      SRC <= 9'h000;
    end else if (IRQ_RESUME || SYS_RESET) begin
      SRC <= 9'h000; // Served or wiped by reset
    end else begin
      SRC <= SRC | SET; // Levels accumulate
    end
  end

  assign IRQ_ANY = |SRC; // Pause wake sees any request
endmodule : smc_partner

// file: bench/standby_mode_controller_bench.sv
`timescale 1ns/1ns
// =====================================
// Bench for the standby controller
module standby_mode_controller_bench;
  localparam int SC = 3; // Short settle keeps the run brief
  // One table row: mode, source, level setup, wake expected
  typedef struct packed {
    logic [1:0] m;
    logic [8:0] s;
    logic [1:0] l;
    logic w;
  } smc_row_type;
  localparam smc_row_type ROWS [18] = '{
    {2'h1, 9'h020, 2'h0, 1'h1}, {2'h1, 9'h001, 2'h0, 1'h1},
    {2'h2, 9'h004, 2'h0, 1'h1}, {2'h2, 9'h008, 2'h0, 1'h1},
    {2'h2, 9'h010, 2'h0, 1'h1}, {2'h2, 9'h020, 2'h0, 1'h1},
    {2'h2, 9'h040, 2'h0, 1'h1}, {2'h2, 9'h001, 2'h1, 1'h1},
    {2'h2, 9'h002, 2'h2, 1'h1}, {2'h2, 9'h001, 2'h0, 1'h0},
    {2'h2, 9'h002, 2'h0, 1'h0}, {2'h2, 9'h080, 2'h0, 1'h0},
    {2'h2, 9'h100, 2'h0, 1'h0}, {2'h3, 9'h080, 2'h0, 1'h1},
    {2'h3, 9'h100, 2'h0, 1'h1}, {2'h3, 9'h001, 2'h1, 1'h1},
    {2'h3, 9'h002, 2'h0, 1'h0}, {2'h3, 9'h040, 2'h0, 1'h1}};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic clr_b = 1'b1; // Clear pin, idle high
  logic wdt = 1'b0;
  logic lsrc_on = 1'b0;
  logic mwr = 1'b0;
  logic [1:0] msel = 2'h0;
  logic [3:0] cfg = 4'hF; // Bit 0 is the crystal setting
  logic [1:0] lvl = 2'h0; // Level detection for pins a, b
  logic [8:0] sset = 9'h000;
  logic [8:0] src;
  logic irq_any;
  logic cpu, per, tk, pll, usb, cer, rc, xt, lsrc, sysr, resm;
  logic [2:0] st;
  logic [7:0] gate;
  int error_cnt = 0;
  int num_checks = 0;

  assign gate = {cpu, per, tk, pll, usb, cer, rc, xt};

  // Free-running 100 MHz clock
  always #5 clk = ~clk;

  smc_partner u_far (.CLK(clk), .RST_B(rst_b), .SET(sset), .IRQ_RESUME(resm),
    .SYS_RESET(sysr), .SRC(src), .IRQ_ANY(irq_any));

  smc_ctrl #(.SETTLE_CYCLES(SC)) u_dut (
    .CLK(clk), .RST_B(rst_b), .EXTERNAL_CLEAR_PIN_B(clr_b), .WDT_RESET(wdt),
    .WDT_LSRC_ON(lsrc_on), .MODE_WR(mwr), .MODE_SEL(msel), .CFG_PLL_ON(cfg[3]),
    .CFG_CERAMIC_ON(cfg[2]), .CFG_RC_ON(cfg[1]), .CFG_XTAL_ON(cfg[0]),
    .IRQ_ANY(irq_any), .EXT_IRQ_PIN_A_REQ(src[0]), .EXT_IRQ_PIN_B_REQ(src[1]),
    .EXT_IRQ_PIN_C_REQ(src[2]), .EXT_IRQ_PIN_E_REQ(src[3]),
    .EXT_IRQ_PIN_F_REQ(src[4]), .EXT_IRQ_PIN_A_LEVEL(lvl[0]),
    .EXT_IRQ_PIN_B_LEVEL(lvl[1]), .PORT0_IRQ(src[5]), .USB_BUS_ACTIVE_IRQ(src[6]),
    .BASE_TIMER_IRQ(src[7]), .IR_RX_IRQ(src[8]), .CPU_RUN_EN(cpu),
    .PERIPH_CLK_EN(per), .TIMEKEEP_CLK_EN(tk), .PLL_REF_EN(pll), .USB_PLL_EN(usb),
    .CERAMIC_RESONATOR_OSC_EN(cer), .RC_OSC_EN(rc), .XTAL_OSC_EN(xt),
    .LSRC_OSC_EN(lsrc), .SYS_RESET(sysr), .IRQ_RESUME(resm), .STANDBY_STATE(st));

  // =====================================
  // Helpers
  // Wait n edges, then step off the edge so updates have landed
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // Single compare for every result, all fit in eight bits
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Gating image per mode from the settings {pll, ceramic, rc, crystal}
  // USB PLL follows its reference, so the pll bit appears twice
  function automatic logic [7:0] egate(input logic [1:0] m, input logic [3:0] c);
    case (m)
      2'h1: egate = {3'h3, c[3], c[3:0]}; // Pause: only the CPU halts
      2'h2: egate = 8'h00; // Full stop: all gated
      2'h3: egate = {7'h10, c[0]}; // Crystal stop keeps timekeeping
      default: egate = {3'h7, c[3], c[3:0]}; // Running
    endcase
  endfunction : egate

  // Software mode write, one-cycle strobe
  task automatic enter(input logic [1:0] m);
    msel = m;
    mwr = 1'b1;
    tick();
    mwr = 1'b0;
    chk("state", {6'h00, m}, {5'h00, st});
    chk("gate", egate(m, cfg), gate);
  endtask : enter

  // Raise a source and time the resume against the settle count
  task automatic wake(input logic [8:0] s, input int en);
    int n;
    n = 0;
    sset = s;
    tick();
    sset = 9'h000;
    while (resm !== 1'b1 && n < 40) begin
      tick();
      n++;
      if (n == 1) chk("settle", (en > 1) ? 8'h04 : 8'h00, {5'h00, st});
    end
    chk("resume", 8'(en), 8'(n));
    chk("gate", egate(2'h0, cfg), gate);
    tick();
    chk("pulse", 8'h00, {7'h00, resm});
  endtask : wake

  // Watchdog reset pulse, then back to run
  task automatic rst_wake();
    wdt = 1'b1;
    tick();
    wdt = 1'b0;
    chk("wdt", 8'h10, {3'h0, sysr, cpu, st});
    tick();
    chk("rerun", 8'h08, {3'h0, sysr, cpu, st});
  endtask : rst_wake

  // Verdict, reached by the tests and the watchdog alike
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  // =====================================
  // Tests
  initial begin
    tick(6);
    chk("in_reset", 8'h00, gate);
    rst_b = 1'b1;
    tick();
    chk("boot", 8'h10, {3'h0, sysr, cpu, st});
    tick(2);
    chk("boot_run", 8'h08, {3'h0, sysr, cpu, st});
    $display("reset test done");
    // Table of wake sources per mode
    foreach (ROWS[i]) begin
      lvl = ROWS[i].l;
      tick();
      enter(ROWS[i].m);
      if (ROWS[i].w) begin
        wake(ROWS[i].s, (ROWS[i].m == 2'h1) ? 1 : SC + 1);
      end else begin
        // Unqualified source must leave the mode standing
        sset = ROWS[i].s;
        tick();
        sset = 9'h000;
        tick(8);
        chk("hold", {6'h00, ROWS[i].m}, {5'h00, st});
        rst_wake();
      end
      tick();
      $display("row %0d done", i);
    end
    // Watchdog reset out of every mode
    for (int m = 1; m < 4; m++) begin
      enter(2'(m));
      rst_wake();
      tick();
    end
    $display("watchdog test done");
    // Mode write with select zero is refused
    mwr = 1'b1;
    msel = 2'h0;
    tick();
    mwr = 1'b0;
    tick();
    chk("nomode", 8'h08, {3'h0, sysr, cpu, st});
    $display("refusal test done");
    // Crystal off at entry stays off though software turns it on
    cfg[0] = 1'b0;
    tick(2);
    enter(2'h3);
    cfg[0] = 1'b1;
    tick(2);
    chk("xtal_hold", 8'h20, gate);
    wake(9'h080, SC + 1);
    tick();
    $display("crystal test done");
    // Pause keeps partial oscillator settings as they were
    cfg = 4'h5;
    tick(2);
    enter(2'h1);
    wake(9'h020, 1);
    cfg = 4'hF;
    tick(2);
    $display("pause oscillator test done");
    // Slow RC follows watchdog control even in full stop
    enter(2'h2);
    lsrc_on = 1'b1;
    tick();
    chk("lsrc_on", 8'h01, {7'h00, lsrc});
    lsrc_on = 1'b0;
    tick();
    chk("lsrc_off", 8'h00, {7'h00, lsrc});
    wake(9'h040, SC + 1);
    tick();
    $display("slow oscillator test done");
    // Clear pin out of crystal stop, through the synchroniser
    enter(2'h3);
    clr_b = 1'b0;
    tick(3);
    chk("clear", 8'h10, {3'h0, sysr, cpu, st});
    clr_b = 1'b1;
    tick(4);
    chk("clear_run", 8'h08, {3'h0, sysr, cpu, st});
    $display("clear pin test done");
    close_out();
  end

  // Cuts a hang short; the tests need well under a tenth of this
  initial begin
    #100000;
    error_cnt++;
    $display("watchdog expired");
    close_out();
  end
endmodule : standby_mode_controller_bench
